// [core/fsw_sequencer.sv]
`timescale 1ns/100ps
// Summary of operation
// R1: Programming never erases; it only writes latched words into the row.
// R2: Software programs only erased or never-written words.
// R3: An erase clears exactly one addressed row.
// R4: One program operation writes at most the sixteen latches.
// R5: Upper eleven address bits pick the row, low four pick the latch.
// R6: Programming stays within the addressed row, never crossing its boundary.
// R7: Every program or erase end resets all latches to 0x3FFF.
// R8: Latch-only unlocked start copies data pair into latch, no flash cycle.
// R9: Normal unlocked start loads final word then programs whole row.
// R10: Only an uninterrupted unlock sequence loads latches or programs.
// R11: Software sets enable, clears config select, loads latches, steps address.
// R12: Latch load forces two no-op cycles then runs on without stall.
// R13: Row program forces two no-ops, stalls, resumes at third instruction.
// R14: Software should mask interrupts around each unlock sequence.
// R15: Software rewrites partial rows via RAM image, erase, reload, program.
// R16: Config select redirects access to ID and configuration word region.
// R17: User IDs read/write; device, revision and config words read-only.
// R18: Config read outside permitted set clears the data pair to zero.
// R19: Software should verify the programmed row against its RAM copy.
// R20: Unlock is 55h then AAh to the key register, then start bit.
// R21: Starts accepted only with write enable set; enable clear at reset.
// R22: Write error flag marks a program or erase cut short by reset.
// R23: Each latch holds six high-register bits and eight low-register bits.
// R24: Self-timed stall length is a parameter for short simulations.
module fsw_sequencer
    import fsw_pkg::*;
#(
    parameter int PROG_CYCLES_P = PROG_CYCLES
)
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic POR_B,
    input wire logic CE,
    input wire logic SFR_WE,
    input wire logic [2:0] SFR_SEL,
    input wire logic [7:0] SFR_WDATA,
    input wire logic IRQ_TAKEN,
    input wire logic [WORD_W-1:0] FLASH_RD_DATA,
    output logic [7:0] PROG_ADDR_HIGH,
    output logic [7:0] PROG_ADDR_LOW,
    output logic [7:0] PROG_DATA_HIGH,
    output logic [7:0] PROG_DATA_LOW,
    output logic [7:0] FLASH_CONTROL,
    output fsw_flash_cmd_t FLASH_CMD,
    output fsw_row_t FLASH_ROW_DATA,
    output logic CPU_FORCE_NOP,
    output logic CPU_STALL
);
    fsw_state_t state_reg, state_next;
    fsw_key_t key_reg, key_next;
    fsw_ctrl_t ctrl_reg, ctrl_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    fsw_word_t data_reg, data_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic write_error_flag_reg, write_error_flag_next;
    logic op_erase_reg, op_long_reg, op_allow_reg;
    logic prog_reg, erase_reg;

    function automatic logic sfr_hit(input logic we, input logic [2:0] sel,
                                     input logic [2:0] want);
        sfr_hit = we && (sel == want);
    endfunction

    function automatic logic cfg_low(input logic [ADDR_W-1:0] a);
        cfg_low = (a[ADDR_W-1:LATCH_IDX_W] == '0);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Decode
    wire logic hit_ctrl = sfr_hit(SFR_WE, SFR_SEL, SEL_CONTROL);
    wire logic hit_key = sfr_hit(SFR_WE, SFR_SEL, SEL_KEY);
    wire logic hit_alow = sfr_hit(SFR_WE, SFR_SEL, SEL_ADDR_LOW);
    wire logic hit_ahigh = sfr_hit(SFR_WE, SFR_SEL, SEL_ADDR_HIGH);
    wire logic hit_dlow = sfr_hit(SFR_WE, SFR_SEL, SEL_DATA_LOW);
    wire logic hit_dhigh = sfr_hit(SFR_WE, SFR_SEL, SEL_DATA_HIGH);
    wire logic idle = (state_reg == FSW_IDLE);
    wire logic [3:0] word_sel = addr_reg[LATCH_IDX_W-1:0];
    wire logic cfg_read_ok = cfg_low(addr_reg) &&
        (word_sel <= CFG_USER_ID_LAST ||
         (word_sel >= CFG_READ_FIRST && word_sel <= CFG_READ_LAST)); // [R17]
    wire logic cfg_write_ok = cfg_low(addr_reg) && word_sel <= CFG_USER_ID_LAST; // [R17]
    // Write enable taken from the same write, as a bit-set leaves it in place
    wire logic start_ok = hit_ctrl && SFR_WDATA[CTRL_WR_BIT] && SFR_WDATA[CTRL_WRITE_ENABLE_BIT_BIT] &&
        key_reg == KEY_ARMED && idle && !IRQ_TAKEN; // [R10] [R21]
    wire logic start_erase = SFR_WDATA[CTRL_FREE_BIT];
    // Latch-only is ignored for erase
    wire logic start_long = start_erase || !SFR_WDATA[CTRL_LATCH_ONLY_SELECT_BIT]; // [R8] [R9]
    wire logic start_cfg = SFR_WDATA[CTRL_CONFIG_SPACE_SELECT_BIT];
    wire logic start_allow = start_erase ? !start_cfg : (!start_cfg || cfg_write_ok); // [R16]
    wire logic rd_start = hit_ctrl && SFR_WDATA[CTRL_RD_BIT] && idle;
    wire logic stall_end = (state_reg == FSW_STALL) && (cnt_reg == '0);
    wire logic load_end = (state_reg == FSW_NOP2) && !op_long_reg;
    wire logic op_done = stall_end || load_end;
    wire logic latch_load = start_ok && !start_erase; // [R8] [R9]

    ////////////////////////////////////////////////////////////////////////////////
    // Unlock key tracking: any other write or a taken interrupt breaks the chain
    always_comb begin
        key_next = key_reg;
        if (IRQ_TAKEN) begin
            key_next = KEY_IDLE; // [R10]
        end else if (hit_key && SFR_WDATA == KEY_FIRST) begin
            key_next = KEY_GOT_FIRST; // [R20]
        end else if (hit_key && SFR_WDATA == KEY_SECOND && key_reg == KEY_GOT_FIRST) begin
            key_next = KEY_ARMED; // [R20]
        end else if (SFR_WE) begin
            key_next = KEY_IDLE; // [R10]
        end
    end

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            FSW_IDLE: begin
                if (start_ok) begin
                    state_next = FSW_NOP1; // [R12] [R13]
                end
            end
            FSW_NOP1: begin
                state_next = FSW_NOP2;
            end
            FSW_NOP2: begin
                if (op_long_reg) begin
                    state_next = FSW_STALL; // [R13]
                    cnt_next = CNT_W'(PROG_CYCLES_P - 1); // [R24]
                end else begin
                    state_next = FSW_IDLE; // [R12]
                end
            end
            FSW_STALL: begin
                if (cnt_reg == '0) begin
                    state_next = FSW_IDLE;
                end else begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end
            end
            default: begin
                state_next = FSW_IDLE;
            end
        endcase
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        if (hit_ctrl) begin
            ctrl_next.config_space_select = SFR_WDATA[CTRL_CONFIG_SPACE_SELECT_BIT];
            ctrl_next.latch_only_select = SFR_WDATA[CTRL_LATCH_ONLY_SELECT_BIT];
            ctrl_next.free = SFR_WDATA[CTRL_FREE_BIT];
            ctrl_next.write_enable_bit = SFR_WDATA[CTRL_WRITE_ENABLE_BIT_BIT];
        end
        // Start and read bits are set-only, and only take effect when accepted
        ctrl_next.rd = rd_start;
        if (start_ok) begin
            ctrl_next.wr = 1'b1;
        end else if (op_done) begin
            ctrl_next.wr = 1'b0;
        end
        if (stall_end && op_erase_reg) begin
            ctrl_next.free = 1'b0;
        end
    end

    // Raised at every start, dropped on a clean finish, otherwise written by a control register write
    always_comb begin
        write_error_flag_next = write_error_flag_reg;
        if (start_ok) begin
            write_error_flag_next = 1'b1; // [R22]
        end else if (op_done) begin
            write_error_flag_next = 1'b0;
        end else if (hit_ctrl) begin
            write_error_flag_next = SFR_WDATA[CTRL_WRITE_ERROR_FLAG_BIT];
        end
    end

    always_comb begin
        addr_next = addr_reg;
        data_next = data_reg;
        if (hit_alow) begin
            addr_next[7:0] = SFR_WDATA;
        end
        if (hit_ahigh) begin
            addr_next[ADDR_W-1:8] = SFR_WDATA[6:0];
        end
        if (hit_dlow) begin
            data_next[7:0] = SFR_WDATA;
        end
        if (hit_dhigh) begin
            data_next[WORD_W-1:8] = SFR_WDATA[5:0];
        end
        if (ctrl_reg.rd) begin
            data_next = (ctrl_reg.config_space_select && !cfg_read_ok) ? '0 : FLASH_RD_DATA; // [R18]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= FSW_IDLE;
            key_reg <= KEY_IDLE;
            ctrl_reg <= '0; // [R21]
            addr_reg <= ADDR_RESET;
            data_reg <= '0;
            cnt_reg <= '0;
        end else if (CE) begin
            state_reg <= state_next;
            key_reg <= key_next;
            ctrl_reg <= ctrl_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            op_erase_reg <= 1'b0;
            op_long_reg <= 1'b0;
            op_allow_reg <= 1'b0;
            prog_reg <= 1'b0;
            erase_reg <= 1'b0;
        end else if (CE) begin
            if (start_ok) begin
                op_erase_reg <= start_erase;
                op_long_reg <= start_long;
                op_allow_reg <= start_allow;
            end
            // Program path carries no erase pulse
            prog_reg <= state_reg == FSW_NOP2 && op_long_reg && !op_erase_reg &&
                op_allow_reg; // [R1] [R9]
            erase_reg <= state_reg == FSW_NOP2 && op_erase_reg && op_allow_reg; // [R3]
        end
    end

    // Of the two resets, only power-on clears this, so a cut-short operation stays visible
    always_ff @(posedge CLK or negedge POR_B) begin
        if (!POR_B) begin
            write_error_flag_reg <= 1'b0;
        end else if (CE) begin
            write_error_flag_reg <= write_error_flag_next; // [R22]
        end
    end

    fsw_latch_bank u_latch_bank (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .load(latch_load),
        .blank_all(stall_end),
        .index(word_sel),
        .word(data_reg),
        .row_data(FLASH_ROW_DATA)
    ); // [R4] [R6] [R7]

    ////////////////////////////////////////////////////////////////////////////////
    assign PROG_ADDR_LOW = addr_reg[7:0];
    assign PROG_ADDR_HIGH = {UNIMPL_HIGH, addr_reg[ADDR_W-1:8]};
    assign PROG_DATA_LOW = data_reg[7:0];
    assign PROG_DATA_HIGH = {2'h0, data_reg[WORD_W-1:8]};
    assign FLASH_CONTROL = {UNIMPL_HIGH, ctrl_reg.config_space_select, ctrl_reg.latch_only_select, ctrl_reg.free,
                            write_error_flag_reg, ctrl_reg.write_enable_bit, ctrl_reg.wr, ctrl_reg.rd};
    // Row is the upper address bits; the array ignores the low four on program
    assign FLASH_CMD = {ctrl_reg.rd, prog_reg, erase_reg, ctrl_reg.config_space_select, addr_reg}; // [R5]
    assign CPU_FORCE_NOP = (state_reg == FSW_NOP1) || (state_reg == FSW_NOP2);
    assign CPU_STALL = (state_reg == FSW_STALL);

    ////////////////////////////////////////////////////////////////////////////////
    property p_prog_no_erase;
        @(posedge CLK) disable iff (!RST_B || !CE)
        FLASH_CMD.prog |-> !FLASH_CMD.erase ##1 !FLASH_CMD.erase;
    endproperty
    a_prog_no_erase: assert property (p_prog_no_erase) else $error("erase during program"); // [R1]

    property p_erase_once;
        @(posedge CLK) disable iff (!RST_B || !CE)
        FLASH_CMD.erase |-> CPU_STALL ##1 !FLASH_CMD.erase;
    endproperty
    a_erase_once: assert property (p_erase_once) else $error("erase not single pulse"); // [R3]

    property p_latch_only;
        @(posedge CLK) disable iff (!RST_B || !CE)
        start_ok && !start_long |=> CPU_FORCE_NOP[*2] ##1 (!CPU_FORCE_NOP && !CPU_STALL);
    endproperty
    a_latch_only: assert property (p_latch_only) else $error("latch load sequence wrong"); // [R12]

    property p_row_prog;
        @(posedge CLK) disable iff (!RST_B || !CE)
        start_ok && start_long && !start_erase && !start_cfg
            |=> CPU_FORCE_NOP[*2] ##1 (CPU_STALL && FLASH_CMD.prog);
    endproperty
    a_row_prog: assert property (p_row_prog) else $error("row program sequence wrong"); // [R13]

    property p_no_flash_on_load;
        @(posedge CLK) disable iff (!RST_B || !CE)
        start_ok && !start_long |=> (!FLASH_CMD.prog)[*3];
    endproperty
    a_no_flash_on_load: assert property (p_no_flash_on_load) else $error("flash cycle on load"); // [R8]

    property p_irq_breaks;
        @(posedge CLK) disable iff (!RST_B || !CE)
        IRQ_TAKEN |=> !start_ok;
    endproperty
    a_irq_breaks: assert property (p_irq_breaks) else $error("start after interrupt"); // [R10]

    property p_write_enable_bit_gate;
        @(posedge CLK) disable iff (!RST_B || !CE)
        idle && hit_ctrl && !SFR_WDATA[CTRL_WRITE_ENABLE_BIT_BIT] |=> idle && !FLASH_CONTROL[CTRL_WR_BIT];
    endproperty
    a_write_enable_bit_gate: assert property (p_write_enable_bit_gate) else $error("start without enable"); // [R21]

    property p_write_error_flag_set;
        @(posedge CLK) disable iff (!POR_B || !CE)
        start_ok |=> FLASH_CONTROL[CTRL_WRITE_ERROR_FLAG_BIT];
    endproperty
    a_write_error_flag_set: assert property (p_write_error_flag_set) else $error("error flag not raised"); // [R22]

    property p_cfg_write;
        @(posedge CLK) disable iff (!RST_B || !CE)
        FLASH_CMD.prog && FLASH_CMD.cfg |-> cfg_write_ok;
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("read-only word programmed"); // [R17]

    property p_cfg_read_zero;
        @(posedge CLK) disable iff (!RST_B || !CE)
        ctrl_reg.rd && ctrl_reg.config_space_select && !cfg_read_ok |=> PROG_DATA_LOW == 8'h00 &&
            PROG_DATA_HIGH == 8'h00;
    endproperty
    a_cfg_read_zero: assert property (p_cfg_read_zero) else $error("bad read not zero"); // [R18]
endmodule

// [pkg/fsw_pkg.sv]
package fsw_pkg;
    localparam int LATCH_COUNT = 16;
    localparam int LATCH_IDX_W = 4;
    localparam int WORD_W = 14;
    localparam int ADDR_W = 15;
    localparam int ROW_W = 11;
    localparam int CNT_W = 17;

    localparam logic [WORD_W-1:0] BLANK_WORD = 14'h3fff;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic UNIMPL_HIGH = 1'b1;

    // Register selects on the special-function write port
    localparam logic [2:0] SEL_ADDR_LOW = 3'h0;
    localparam logic [2:0] SEL_ADDR_HIGH = 3'h1;
    localparam logic [2:0] SEL_DATA_LOW = 3'h2;
    localparam logic [2:0] SEL_DATA_HIGH = 3'h3;
    localparam logic [2:0] SEL_CONTROL = 3'h4;
    localparam logic [2:0] SEL_KEY = 3'h5;

    // Control register bit positions
    localparam int CTRL_CONFIG_SPACE_SELECT_BIT = 6;
    localparam int CTRL_LATCH_ONLY_SELECT_BIT = 5;
    localparam int CTRL_FREE_BIT = 4;
    localparam int CTRL_WRITE_ERROR_FLAG_BIT = 3;
    localparam int CTRL_WRITE_ENABLE_BIT_BIT = 2;
    localparam int CTRL_WR_BIT = 1;
    localparam int CTRL_RD_BIT = 0;

    // Configuration space word offsets
    localparam logic [3:0] CFG_USER_ID_LAST = 4'h3;
    localparam logic [3:0] CFG_READ_FIRST = 4'h5;
    localparam logic [3:0] CFG_READ_LAST = 4'h9;

    localparam int CLK_FREQ_HZ = 25000000;
    localparam int PROG_TIME_US = 2000;
    localparam int PROG_CYCLES = PROG_TIME_US * (CLK_FREQ_HZ / 1000000);

    typedef logic [WORD_W-1:0] fsw_word_t;
    typedef fsw_word_t [LATCH_COUNT-1:0] fsw_row_t;
    localparam fsw_row_t BLANK_ROW = {LATCH_COUNT{BLANK_WORD}};

    typedef enum logic [1:0] {FSW_IDLE, FSW_NOP1, FSW_NOP2, FSW_STALL} fsw_state_t;
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} fsw_key_t;

    typedef struct packed {
        logic config_space_select;
        logic latch_only_select;
        logic free;
        logic write_enable_bit;
        logic wr;
        logic rd;
    } fsw_ctrl_t;

    typedef struct packed {
        logic rd;
        logic prog;
        logic erase;
        logic cfg;
        logic [ADDR_W-1:0] addr;
    } fsw_flash_cmd_t;
endpackage

// [core/fsw_latch_bank.sv]
`timescale 1ns/100ps
module fsw_latch_bank
    import fsw_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic load,
    input wire logic blank_all,
    input wire logic [LATCH_IDX_W-1:0] index,
    input wire fsw_word_t word,
    output fsw_row_t row_data
);
    fsw_word_t latch_reg [LATCH_COUNT];

    genvar g;
    generate
        for (g = 0; g < LATCH_COUNT; g++) begin : g_latch
            wire logic sel = load && (index == LATCH_IDX_W'(g)); // [R5]
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    latch_reg[g] <= BLANK_WORD;
                end else if (ce) begin
                    if (blank_all) begin
                        latch_reg[g] <= BLANK_WORD; // [R7]
                    end else if (sel) begin
                        latch_reg[g] <= word; // [R23]
                    end
                end
            end
            assign row_data[g] = latch_reg[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    property p_latch_load;
        @(posedge clk) disable iff (!rst_b || !ce)
        load && !blank_all |=> row_data[$past(index)] == $past(word);
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("latch not loaded"); // [R5]

    property p_blank;
        @(posedge clk) disable iff (!rst_b || !ce)
        blank_all |=> row_data == BLANK_ROW;
    endproperty
    a_blank: assert property (p_blank) else $error("latches not blanked"); // [R7]
endmodule

// [dv/test_fsw_sequencer.sv]
`timescale 1ns/100ps
module test_fsw_sequencer
    import fsw_pkg::*;
;
    localparam int P = 20;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic por_b = 1'b0;
    logic ce = 1'b1;
    logic sfr_we = 1'b0;
    logic [2:0] sfr_sel = 3'h0;
    logic [7:0] sfr_wdata = 8'h00;
    logic irq_taken = 1'b0;
    logic [WORD_W-1:0] flash_rd = 14'h0000;
    logic [7:0] prog_addr_high, prog_addr_low, prog_data_high, prog_data_low, flash_control;
    fsw_flash_cmd_t flash_cmd;
    fsw_row_t flash_row_data, exp_row;
    logic cpu_force_nop, cpu_stall;
    logic [ADDR_W-1:0] cur_addr = 15'h0000;
    int failures = 0;
    int checks = 0;
    int n_prog = 0;
    int n_erase = 0;

    fsw_sequencer #(.PROG_CYCLES_P(P)) fsw_sequencer_inst (
        .CLK(clk), .RST_B(rst_b), .POR_B(por_b), .CE(ce), .SFR_WE(sfr_we),
        .SFR_SEL(sfr_sel), .SFR_WDATA(sfr_wdata), .IRQ_TAKEN(irq_taken),
        .FLASH_RD_DATA(flash_rd), .PROG_ADDR_HIGH(prog_addr_high),
        .PROG_ADDR_LOW(prog_addr_low), .PROG_DATA_HIGH(prog_data_high),
        .PROG_DATA_LOW(prog_data_low), .FLASH_CONTROL(flash_control), .FLASH_CMD(flash_cmd),
        .FLASH_ROW_DATA(flash_row_data), .CPU_FORCE_NOP(cpu_force_nop), .CPU_STALL(cpu_stall)
    );

    always #20 clk = ~clk;

    // Pulse tally catches strays outside the expected cycles
    always @(posedge clk) begin
        if (flash_cmd.prog === 1'b1) n_prog++;
        if (flash_cmd.erase === 1'b1) n_erase++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_row(input string nm, input fsw_row_t exp, input fsw_row_t got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        @(posedge clk);
        sfr_we <= 1'b1;
        sfr_sel <= sel;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_we <= 1'b0;
    endtask

    task automatic set_addr(input logic [ADDR_W-1:0] a);
        wr(SEL_ADDR_HIGH, {1'b0, a[14:8]});
        wr(SEL_ADDR_LOW, a[7:0]);
        cur_addr = a;
        #1;
        chk("addr_high", {8'h80 | {1'b0, a[14:8]}}, prog_addr_high);
        chk("addr_low", a[7:0], prog_addr_low);
    endtask

    // Top bits set on purpose: only six high bits may reach the latch
    task automatic set_data(input logic [WORD_W-1:0] w);
        wr(SEL_DATA_HIGH, {2'b11, w[13:8]});
        wr(SEL_DATA_LOW, w[7:0]);
    endtask

    task automatic start_op(input logic [7:0] ctrl, input logic lng, prg, ers);
        wr(SEL_KEY, KEY_FIRST);
        wr(SEL_KEY, KEY_SECOND);
        wr(SEL_CONTROL, ctrl);
        #1;
        chk("nop_c1", 1, cpu_force_nop);
        chk("ctrl_c1", 8'h8a | (ctrl & 8'h74), flash_control);
        @(posedge clk);
        #1;
        chk("nop_c2", 1, cpu_force_nop);
        @(posedge clk);
        #1;
        chk("nop_c3", 0, cpu_force_nop);
        chk("stall_c3", lng, cpu_stall);
        chk("prog_pulse", prg, flash_cmd.prog);
        chk("erase_pulse", ers, flash_cmd.erase);
        if (prg) chk("prog_addr", cur_addr, flash_cmd.addr);
        if (!ctrl[6]) chk_row("row_c3", exp_row, flash_row_data);
        if (lng) begin
            repeat (P - 1) @(posedge clk);
            #1;
            chk("stall_last", 1, cpu_stall);
            @(posedge clk);
            #1;
            chk("stall_end", 0, cpu_stall);
            chk_row("row_blank", BLANK_ROW, flash_row_data);
            exp_row = BLANK_ROW;
        end
        chk("ctrl_done", 8'h80 | (ctrl & 8'h64), flash_control);
    endtask

    task automatic do_read(input logic [ADDR_W-1:0] a, input logic [7:0] ctrl, input logic ok);
        logic [WORD_W-1:0] w;
        w = 14'h2c3a ^ {6'h00, a[7:0]};
        set_addr(a);
        flash_rd <= w;
        wr(SEL_CONTROL, ctrl);
        #1;
        chk("rd_pulse", 1, flash_cmd.rd);
        chk("rd_bit", 1, flash_control[0]);
        chk("rd_space", ctrl[6], flash_cmd.cfg);
        @(posedge clk);
        #1;
        if (!ok) w = 14'h0000;
        chk("data_high", {2'b00, w[13:8]}, prog_data_high);
        chk("data_low", w[7:0], prog_data_low);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6000) @(posedge clk);
        failures++;
        report_and_stop();
    end

    initial begin
        logic [WORD_W-1:0] w;
        exp_row = BLANK_ROW;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        @(posedge clk);
        #1;
        chk("rst_ctrl", 8'h80, flash_control);
        chk("rst_addr_high", 8'h80, prog_addr_high);
        chk("rst_stall", 0, cpu_stall);
        chk_row("rst_row", BLANK_ROW, flash_row_data);
        // No key, broken chain, interrupt in chain, write enable clear
        for (int k = 0; k < 4; k++) begin
            if (k > 0) wr(SEL_KEY, KEY_FIRST);
            if (k == 1) wr(SEL_ADDR_LOW, 8'h00);
            if (k == 2) begin
                @(posedge clk);
                irq_taken <= 1'b1;
                @(posedge clk);
                irq_taken <= 1'b0;
            end
            if (k > 0) wr(SEL_KEY, KEY_SECOND);
            wr(SEL_CONTROL, (k == 3) ? 8'h22 : 8'h26);
            #1;
            chk("refused_nop", 0, cpu_force_nop);
            chk("refused_ctrl", (k == 3) ? 8'ha0 : 8'ha4, flash_control);
            repeat (3) @(posedge clk);
            #1;
            chk_row("refused_row", BLANK_ROW, flash_row_data);
        end
        do_read(15'h0456, 8'h01, 1'b1);
        for (int i = 0; i < 11; i++) begin
            do_read(15'(i), 8'h41, (i < 4) || (i >= 5 && i <= 9));
        end
        do_read(15'h0013, 8'h41, 1'b0);
        // Fill a whole row, the last word arriving with the program start
        for (int i = 0; i < LATCH_COUNT; i++) begin
            w = 14'h1a50 + 14'(i * 7);
            set_addr(15'h0120 + 15'(i));
            set_data(w);
            exp_row[i] = w;
            start_op((i == LATCH_COUNT - 1) ? 8'h06 : 8'h26, i == LATCH_COUNT - 1,
                     i == LATCH_COUNT - 1, 1'b0);
        end
        set_addr(15'h0123);
        start_op(8'h36, 1'b1, 1'b0, 1'b1);
        set_addr(15'h0002);
        set_data(14'h0abc);
        start_op(8'h46, 1'b1, 1'b1, 1'b0);
        set_addr(15'h0005);
        start_op(8'h46, 1'b1, 1'b0, 1'b0);
        chk("prog_total", 2, 16'(n_prog));
        chk("erase_total", 1, 16'(n_erase));
        // Reset while the row program is stalled
        wr(SEL_KEY, KEY_FIRST);
        wr(SEL_KEY, KEY_SECOND);
        wr(SEL_CONTROL, 8'h06);
        repeat (5) @(posedge clk);
        // Enable low freezes the stall count, so the stall outlives its length
        ce <= 1'b0;
        repeat (P) @(posedge clk);
        ce <= 1'b1;
        #1;
        chk("ce_frozen", 1, cpu_stall);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk("err_after_rst", 8'h88, flash_control);
        chk("stall_after_rst", 0, cpu_stall);
        @(posedge clk);
        por_b <= 1'b0;
        @(posedge clk);
        por_b <= 1'b1;
        #1;
        chk("ctrl_after_por", 8'h80, flash_control);
        report_and_stop();
    end
endmodule
